//--- rtl/kmp_ports.sv
// key matrix port groups with standby wake request and axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module kmp_ports #(
    parameter int FLEX_W = 3, // three_pin_flex_port width
    parameter int QUAD_W = 4  // width of the four-pin ports
) (
    input  wire logic              core_clk,        // 200 mhz clock
    input  wire logic              rst,             // async reset, high
    input  wire logic [7:0]        s_axi_awaddr,    // write address
    input  wire logic              s_axi_awvalid,   // write address valid
    output logic                   s_axi_awready,   // write address ready
    input  wire logic [31:0]       s_axi_wdata,     // write data
    input  wire logic [3:0]        s_axi_wstrb,     // write strobes
    input  wire logic              s_axi_wvalid,    // write data valid
    output logic                   s_axi_wready,    // write data ready
    output logic [1:0]             s_axi_bresp,     // write response
    output logic                   s_axi_bvalid,    // write response valid
    input  wire logic              s_axi_bready,    // write response ready
    input  wire logic [7:0]        s_axi_araddr,    // read address
    input  wire logic              s_axi_arvalid,   // read address valid
    output logic                   s_axi_arready,   // read address ready
    output logic [31:0]            s_axi_rdata,     // read data
    output logic [1:0]             s_axi_rresp,     // read response
    output logic                   s_axi_rvalid,    // read data valid
    input  wire logic              s_axi_rready,    // read data ready
    input  wire logic [FLEX_W-1:0] flex_in,         // three_pin_flex_port level
    output logic [FLEX_W-1:0]      flex_out,        // output value
    output logic [FLEX_W-1:0]      flex_oe,         // output enable
    output logic [FLEX_W-1:0]      flex_pu_en,      // pull-up on
    output logic [FLEX_W-1:0]      flex_pd_en,      // pull-down on
    output logic [FLEX_W-1:0]      flex_hi_drive,   // strong push-pull
    input  wire logic [QUAD_W-1:0] iok_in,          // input_only_key_port level
    output logic [QUAD_W-1:0]      iok_pu_en,       // pull-ups, always on
    input  wire logic [QUAD_W-1:0] ppd_in,          // per_pin_dir_port level
    output logic [QUAD_W-1:0]      ppd_out,         // output value
    output logic [QUAD_W-1:0]      ppd_oe,          // output enable
    output logic [QUAD_W-1:0]      ppd_pu_en,       // pull-up on
    input  wire logic [QUAD_W-1:0] grp_in,          // group_dir_port level
    output logic [QUAD_W-1:0]      grp_out,         // output value
    output logic [QUAD_W-1:0]      grp_oe,          // output enable
    output logic [QUAD_W-1:0]      grp_pu_en,       // pull-up on
    output logic                   wake_req,        // standby release request
    output logic                   irq              // interrupt, level high
);
    initial
    begin
        if (FLEX_W < 1 || FLEX_W > 4 || QUAD_W < 1 || QUAD_W > 4)
            $error("port widths must be 1 to 4");
    end

    // =================================================================
    // pin synchronisers
    logic [FLEX_W-1:0] flex_s1, flex_s2;
    logic [QUAD_W-1:0] iok_s1, iok_s2, ppd_s1, ppd_s2, grp_s1, grp_s2;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            flex_s1 <= '0;
            flex_s2 <= '0;
            iok_s1  <= '1;
            iok_s2  <= '1;
            ppd_s1  <= '1;
            ppd_s2  <= '1;
            grp_s1  <= '1;
            grp_s2  <= '1;
        end
        else
        begin
            flex_s1 <= flex_in;
            flex_s2 <= flex_s1;
            iok_s1  <= iok_in;
            iok_s2  <= iok_s1;
            ppd_s1  <= ppd_in;
            ppd_s2  <= ppd_s1;
            grp_s1  <= grp_in;
            grp_s2  <= grp_s1;
        end
    end

    // =================================================================
    // control registers
    logic              key_mode;
    logic              grp_dir;     // 1 = output
    logic [FLEX_W-1:0] flex_dir;    // 1 = output
    logic [FLEX_W-1:0] flex_res;    // resistor enable
    logic [FLEX_W-1:0] flex_sel;    // 1 = pull-up in both modes; key mode: 1 = wake on low
    logic [FLEX_W-1:0] flex_val;
    logic [QUAD_W-1:0] ppd_dir;
    logic [QUAD_W-1:0] ppd_val;
    logic [QUAD_W-1:0] grp_val;
    logic              irq_stat;
    logic              irq_mask;

    logic       aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic       do_write;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    function automatic logic known_addr(input logic [7:0] a);
        case (a)
            kmp_pkg::ADDR_CTRL, kmp_pkg::ADDR_FLEX_DIR, kmp_pkg::ADDR_FLEX_RES,
            kmp_pkg::ADDR_FLEX_SEL, kmp_pkg::ADDR_FLEX_OUT, kmp_pkg::ADDR_PPD_DIR,
            kmp_pkg::ADDR_PPD_OUT, kmp_pkg::ADDR_GRP_OUT, kmp_pkg::ADDR_PINS,
            kmp_pkg::ADDR_IRQ_STAT, kmp_pkg::ADDR_IRQ_MASK: known_addr = 1'b1;
            default: known_addr = 1'b0;
        endcase
    endfunction

    // write channel: address and data taken in either order
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= kmp_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(aw_addr) ? kmp_pkg::RESP_OKAY
                                                    : kmp_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_lane0;
    assign wr_lane0 = do_write && w_strb[0];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            key_mode <= kmp_pkg::CTRL_RST[kmp_pkg::CTRL_KEY_MODE];
            grp_dir  <= kmp_pkg::CTRL_RST[kmp_pkg::CTRL_GRP_DIR];
            flex_dir <= '0;
            flex_res <= '0;
            flex_sel <= '0;
            flex_val <= '0;
            ppd_dir  <= '0;
            ppd_val  <= '1;
            grp_val  <= kmp_pkg::GRP_OUT_RST[QUAD_W-1:0];
            irq_mask <= 1'b0;
        end
        else if (wr_lane0)
        begin
            case (aw_addr)
                kmp_pkg::ADDR_CTRL:
                begin
                    key_mode <= w_data[kmp_pkg::CTRL_KEY_MODE];
                    grp_dir  <= w_data[kmp_pkg::CTRL_GRP_DIR];
                end
                kmp_pkg::ADDR_FLEX_DIR: flex_dir <= w_data[FLEX_W-1:0];
                kmp_pkg::ADDR_FLEX_RES: flex_res <= w_data[FLEX_W-1:0];
                kmp_pkg::ADDR_FLEX_SEL: flex_sel <= w_data[FLEX_W-1:0];
                kmp_pkg::ADDR_FLEX_OUT: flex_val <= w_data[FLEX_W-1:0];
                kmp_pkg::ADDR_PPD_DIR:  ppd_dir  <= w_data[QUAD_W-1:0];
                kmp_pkg::ADDR_PPD_OUT:  ppd_val  <= w_data[QUAD_W-1:0];
                kmp_pkg::ADDR_GRP_OUT:  grp_val  <= w_data[QUAD_W-1:0];
                kmp_pkg::ADDR_IRQ_MASK: irq_mask <= w_data[kmp_pkg::IRQ_WAKE];
                default: ;
            endcase
        end
    end

    // =================================================================
    // wake detection
    logic [FLEX_W-1:0] flex_wake_pin;
    logic              next_wake;
    always_comb
    begin
        for (int i = 0; i < FLEX_W; i++)
            // sel=1 wakes on low, sel=0 on high; resistor does not matter
            flex_wake_pin[i] = !flex_dir[i] && (flex_sel[i] ? !flex_s2[i]
                                                            : flex_s2[i]);
        next_wake = (key_mode && |flex_wake_pin)
                  || !(&iok_s2)
                  || |(~ppd_dir & ~ppd_s2)
                  || (!grp_dir && !(&grp_s2));
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wake_req <= 1'b0;
        else
            wake_req <= next_wake;
    end

    // status set wins over write-one-to-clear in the same cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq_stat <= 1'b0;
        else if (next_wake)
            irq_stat <= 1'b1;
        else if (wr_lane0 && aw_addr == kmp_pkg::ADDR_IRQ_STAT
                 && w_data[kmp_pkg::IRQ_WAKE])
            irq_stat <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= irq_stat && irq_mask;
    end

    // =================================================================
    // pad controls, all registered
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            flex_out      <= '0;
            flex_oe       <= '0;
            flex_pu_en    <= '0;
            flex_pd_en    <= '0;
            flex_hi_drive <= '0;
            iok_pu_en     <= '1;
            ppd_out       <= '0;
            ppd_oe        <= '0;
            ppd_pu_en     <= '1;
            grp_out       <= '0;
            grp_oe        <= '1;
            grp_pu_en     <= '0;
        end
        else
        begin
            iok_pu_en <= '1;
            for (int i = 0; i < FLEX_W; i++)
            begin
                if (key_mode)
                begin
                    flex_out[i]      <= 1'b0;
                    flex_oe[i]       <= flex_dir[i] && !flex_val[i];
                    flex_hi_drive[i] <= 1'b0;
                    flex_pu_en[i]    <= !flex_dir[i] && flex_res[i] && flex_sel[i];
                    flex_pd_en[i]    <= !flex_dir[i] && flex_res[i] && !flex_sel[i];
                end
                else
                begin
                    flex_out[i]      <= flex_val[i];
                    flex_oe[i]       <= flex_dir[i];
                    flex_hi_drive[i] <= flex_dir[i];
                    flex_pu_en[i]    <= !flex_dir[i] && flex_res[i] && flex_sel[i];
                    flex_pd_en[i]    <= !flex_dir[i] && flex_res[i] && !flex_sel[i];
                end
            end
            // open drain: pin driven only while the value is low
            ppd_out   <= '0;
            ppd_oe    <= ppd_dir & ~ppd_val;
            ppd_pu_en <= ~ppd_dir;
            grp_out   <= '0;
            grp_oe    <= grp_dir ? ~grp_val : '0;
            grp_pu_en <= grp_dir ? '0 : '1;
        end
    end

    // =================================================================
    // read channel
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            kmp_pkg::ADDR_CTRL:
            begin
                r[kmp_pkg::CTRL_KEY_MODE] = key_mode;
                r[kmp_pkg::CTRL_GRP_DIR]  = grp_dir;
            end
            kmp_pkg::ADDR_FLEX_DIR: r[FLEX_W-1:0] = flex_dir;
            kmp_pkg::ADDR_FLEX_RES: r[FLEX_W-1:0] = flex_res;
            kmp_pkg::ADDR_FLEX_SEL: r[FLEX_W-1:0] = flex_sel;
            kmp_pkg::ADDR_FLEX_OUT: r[FLEX_W-1:0] = flex_val;
            kmp_pkg::ADDR_PPD_DIR:  r[QUAD_W-1:0] = ppd_dir;
            kmp_pkg::ADDR_PPD_OUT:  r[QUAD_W-1:0] = ppd_val;
            kmp_pkg::ADDR_GRP_OUT:  r[QUAD_W-1:0] = grp_val;
            kmp_pkg::ADDR_PINS:
            begin
                r[kmp_pkg::PINS_FLEX_LSB +: FLEX_W] = flex_s2;
                r[kmp_pkg::PINS_IOK_LSB +: QUAD_W]  = iok_s2;
                r[kmp_pkg::PINS_PPD_LSB +: QUAD_W]  = ppd_s2;
                r[kmp_pkg::PINS_GRP_LSB +: QUAD_W]  = grp_s2;
            end
            kmp_pkg::ADDR_IRQ_STAT: r[kmp_pkg::IRQ_WAKE] = irq_stat;
            kmp_pkg::ADDR_IRQ_MASK: r[kmp_pkg::IRQ_WAKE] = irq_mask;
            default: r = 32'h0000_0000;
        endcase
        read_mux = r;
    endfunction

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= kmp_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= read_mux(s_axi_araddr);
                s_axi_rresp  <= known_addr(s_axi_araddr) ? kmp_pkg::RESP_OKAY
                                                         : kmp_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- rtl/kmp_pkg.sv
// constants for the key matrix port block
// =====================================================================
package kmp_pkg;
    // =================================================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00; // key mode, group dir
    localparam logic [7:0] ADDR_FLEX_DIR = 8'h04;
    localparam logic [7:0] ADDR_FLEX_RES = 8'h08;
    localparam logic [7:0] ADDR_FLEX_SEL = 8'h0c; // wake level / pull-up choice
    localparam logic [7:0] ADDR_FLEX_OUT = 8'h10;
    localparam logic [7:0] ADDR_PPD_DIR  = 8'h14;
    localparam logic [7:0] ADDR_PPD_OUT  = 8'h18;
    localparam logic [7:0] ADDR_GRP_OUT  = 8'h1c;
    localparam logic [7:0] ADDR_PINS     = 8'h20; // read-only pin levels
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    // =================================================================
    // field positions
    localparam int CTRL_KEY_MODE = 0;
    localparam int CTRL_GRP_DIR  = 1;
    localparam int PINS_FLEX_LSB = 0;
    localparam int PINS_IOK_LSB  = 4;
    localparam int PINS_PPD_LSB  = 8;
    localparam int PINS_GRP_LSB  = 12;
    localparam int IRQ_WAKE      = 0;
    // =================================================================
    // reset values and bus response codes
    localparam logic [1:0] CTRL_RST     = 2'h3; // key mode on, group output
    localparam logic [3:0] GRP_OUT_RST  = 4'h0;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

//--- test/kmp_ports_asserts.sv
// assertion checker for the key matrix port block
`timescale 1ns/1ps
module kmp_ports_asserts #(
    parameter int FLEX_W = 3, // flex width
    parameter int QUAD_W = 4  // four-pin width
) (
    input wire logic              core_clk,      // clock
    input wire logic              rst,           // reset
    input wire logic              s_axi_bvalid,  // write answer
    input wire logic              s_axi_bready,  // write accept
    input wire logic              s_axi_rvalid,  // read answer
    input wire logic              s_axi_rready,  // read accept
    input wire logic [FLEX_W-1:0] flex_out,      // drive value
    input wire logic [FLEX_W-1:0] flex_oe,       // drive enable
    input wire logic [FLEX_W-1:0] flex_pu_en,    // pull-up
    input wire logic [FLEX_W-1:0] flex_pd_en,    // pull-down
    input wire logic [FLEX_W-1:0] flex_hi_drive, // push-pull
    input wire logic [QUAD_W-1:0] iok_in,        // key returns
    input wire logic [QUAD_W-1:0] iok_pu_en,     // pull-ups
    input wire logic [QUAD_W-1:0] ppd_out,       // drive value
    input wire logic [QUAD_W-1:0] grp_out,       // drive value
    input wire logic [QUAD_W-1:0] grp_oe,        // drive enable
    input wire logic [QUAD_W-1:0] grp_pu_en,     // pull-up
    input wire logic              wake_req,      // wake request
    input wire logic              irq            // interrupt
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // =================================================================
    // pads
    iok_pullup_a: assert property (iok_pu_en == '1) else $error("pull-up off");
    quad_low_a: assert property ((ppd_out | grp_out) == '0) else $error("drives high");
    grp_pull_a: assert property (grp_pu_en == '0 || grp_pu_en == '1) else $error("split");
    grp_dir_a: assert property (|grp_oe |-> grp_pu_en == '0) else $error("pull on out");
    flex_pull_a: assert property ((flex_pu_en & flex_pd_en) == '0) else $error("two pulls");
    flex_strong_a: assert property ((flex_hi_drive & ~flex_oe) == '0) else $error("weak");
    flex_od_a: assert property ((flex_oe & ~flex_hi_drive & flex_out) == '0) else $error("od");
    // =================================================================
    // wake and bus
    // two sync stages plus the request register make three samples
    iok_wake_a: assert property ((iok_in != '1) [*3] |=> wake_req) else $error("no wake");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    cover property (wake_req ##1 !wake_req);
    cover property ($rose(irq));
    cover property (|flex_hi_drive);
endmodule

bind kmp_ports kmp_ports_asserts #(.FLEX_W(FLEX_W), .QUAD_W(QUAD_W)) u_kmp_chk (
    .core_clk(core_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .flex_out(flex_out),
    .flex_oe(flex_oe), .flex_pu_en(flex_pu_en), .flex_pd_en(flex_pd_en),
    .flex_hi_drive(flex_hi_drive), .iok_in(iok_in), .iok_pu_en(iok_pu_en), .ppd_out(ppd_out),
    .grp_out(grp_out), .grp_oe(grp_oe), .grp_pu_en(grp_pu_en), .wake_req(wake_req), .irq(irq));

//--- test/kmp_key_matrix.sv
// key matrix model: one group of lines, each key closing to a given level
`timescale 1ns/1ps
module kmp_key_matrix #(
    parameter int W = 4 // lines in the group
) (
    input wire logic         core_clk, // clock
    input wire logic [W-1:0] drv_out,  // pad drive value
    input wire logic [W-1:0] drv_oe,   // pad drive enable
    input wire logic [W-1:0] pu_en,    // pull-up
    input wire logic [W-1:0] pd_en,    // pull-down
    input wire logic [W-1:0] key,      // key closed
    input wire logic [W-1:0] key_lvl,  // level a closed key brings
    output logic [W-1:0]     lvl       // line level at the pad
);
    // an undriven line without pulls wanders, never a steady 0 or 1
    logic flt = 1'b0;
    always @(posedge core_clk)
        flt <= ~flt;
    // pad driver wins over a key, a key over the weak pulls
    assign lvl = (drv_oe & drv_out) | (~drv_oe & key & key_lvl)
               | (~drv_oe & ~key & (pu_en | (~pd_en & {W{flt}})));
endmodule

//--- test/kmp_ports_tb_top.sv
// self-checking bench for the key matrix port block
`timescale 1ns/1ps
module kmp_ports_tb_top;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, wake_req, irq;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  flex_in, flex_out, flex_oe, flex_pu, flex_pd, flex_hi, fkey = 3'h7, flvl = 3'h0;
    logic [3:0]  iok_in, iok_pu, ppd_in, ppd_out, ppd_oe, ppd_pu, grp_in, grp_out, grp_oe, grp_pu;
    logic [3:0]  ikey = 4'h0, pkey = 4'h0, gkey = 4'h0, qlvl = 4'h0, wstrb = 4'hf;
    int          miscompares = 0, cmp_count = 0, cycles = 0;

    always #2.5 core_clk = ~core_clk;

    kmp_ports dut (
        .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .flex_in(flex_in), .flex_out(flex_out), .flex_oe(flex_oe), .flex_pu_en(flex_pu),
        .flex_pd_en(flex_pd), .flex_hi_drive(flex_hi), .iok_in(iok_in), .iok_pu_en(iok_pu),
        .ppd_in(ppd_in), .ppd_out(ppd_out), .ppd_oe(ppd_oe), .ppd_pu_en(ppd_pu),
        .grp_in(grp_in), .grp_out(grp_out), .grp_oe(grp_oe), .grp_pu_en(grp_pu),
        .wake_req(wake_req), .irq(irq));
    kmp_key_matrix #(.W(3)) u_flex (.core_clk(core_clk), .drv_out(flex_out), .drv_oe(flex_oe),
        .pu_en(flex_pu), .pd_en(flex_pd), .key(fkey), .key_lvl(flvl), .lvl(flex_in));
    kmp_key_matrix #(.W(4)) u_iok (.core_clk(core_clk), .drv_out(4'h0), .drv_oe(4'h0),
        .pu_en(iok_pu), .pd_en(4'h0), .key(ikey), .key_lvl(qlvl), .lvl(iok_in));
    kmp_key_matrix #(.W(4)) u_ppd (.core_clk(core_clk), .drv_out(ppd_out), .drv_oe(ppd_oe),
        .pu_en(ppd_pu), .pd_en(4'h0), .key(pkey), .key_lvl(qlvl), .lvl(ppd_in));
    kmp_key_matrix #(.W(4)) u_grp (.core_clk(core_clk), .drv_out(grp_out), .drv_oe(grp_oe),
        .pu_en(grp_pu), .pd_en(4'h0), .key(gkey), .key_lvl(qlvl), .lvl(grp_in));

    // =================================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ready is sampled at the falling edge: registered outputs hold it to the next rise
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w, b;
        b = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b)
        begin
            @(negedge core_clk);
            aw = awready & awvalid;
            w = wready & wvalid;
            b = bvalid;
            rs = bresp;
            @(posedge core_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar, rv;
        rv = 1'b0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rv)
        begin
            @(negedge core_clk);
            ar = arready & arvalid;
            rv = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge core_clk);
            if (ar) arvalid <= 1'b0;
            if (rv) rready <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        axi_wr(a, v, r);
        chk("bresp", 32'(r), 32'(kmp_pkg::RESP_OKAY));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        axi_rd(a, d, r);
        chk(nm, d, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // pin changes need three edges to reach the wake request
    task automatic keys(input logic [2:0] f, input logic [2:0] l, input logic [3:0] i,
                        input logic [3:0] p, input logic [3:0] g);
        @(posedge core_clk);
        fkey <= f;
        flvl <= l;
        ikey <= i;
        pkey <= p;
        gkey <= g;
        settle(4);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    // =================================================================
    // sequence
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        settle(1);
        chk("flex_rst", 32'({flex_oe, flex_pu, flex_pd}), 32'h0);
        chk("iok_pu", 32'(iok_pu), 32'hf);
        chk("ppd_rst", 32'({ppd_oe, ppd_pu}), 32'h0f);
        chk("grp_rst", 32'({grp_oe, grp_out, grp_pu}), 32'hf00);
        rdc(kmp_pkg::ADDR_CTRL, 32'h3, "ctrl");
        wr(kmp_pkg::ADDR_FLEX_SEL, 32'h0);
        settle(4);
        chk("wake_idle", 32'(wake_req), 32'h0);
        // key mode: pins 0 and 2 wake low, pin 1 wakes high
        wr(kmp_pkg::ADDR_FLEX_RES, 32'h7);
        wr(kmp_pkg::ADDR_FLEX_SEL, 32'h5);
        keys(3'h0, 3'h0, 4'h0, 4'h0, 4'h0);
        chk("flex_pulls", 32'({flex_pu, flex_pd}), 32'h2a);
        chk("wake_none", 32'(wake_req), 32'h0);
        keys(3'h1, 3'h0, 4'h0, 4'h0, 4'h0);
        chk("wake_low", 32'(wake_req), 32'h1);
        keys(3'h2, 3'h2, 4'h0, 4'h0, 4'h0);
        chk("wake_high", 32'(wake_req), 32'h1);
        keys(3'h7, 3'h5, 4'h0, 4'h0, 4'h0);
        wr(kmp_pkg::ADDR_FLEX_RES, 32'h0);
        settle(4);
        chk("flex_float", 32'({flex_pu, flex_pd, wake_req}), 32'h0);
        keys(3'h7, 3'h7, 4'h0, 4'h0, 4'h0);
        chk("wake_float", 32'(wake_req), 32'h1);
        wr(kmp_pkg::ADDR_FLEX_DIR, 32'h7);
        wr(kmp_pkg::ADDR_FLEX_OUT, 32'h2);
        settle(2);
        chk("flex_od", 32'({flex_oe, flex_hi}), 32'h28);
        wr(kmp_pkg::ADDR_CTRL, 32'h2);
        settle(2);
        chk("flex_pp", 32'({flex_oe, flex_hi, flex_out}), 32'h1fa);
        wr(kmp_pkg::ADDR_FLEX_DIR, 32'h1);
        settle(2);
        chk("flex_dir", 32'(flex_oe), 32'h1);
        wr(kmp_pkg::ADDR_FLEX_DIR, 32'h0);
        wr(kmp_pkg::ADDR_FLEX_RES, 32'h7);
        wr(kmp_pkg::ADDR_FLEX_SEL, 32'h3);
        settle(2);
        chk("flex_norm", 32'({flex_pu, flex_pd}), 32'h1c);
        // four-pin ports
        wr(kmp_pkg::ADDR_PPD_DIR, 32'h5);
        wr(kmp_pkg::ADDR_PPD_OUT, 32'h0);
        keys(3'h7, 3'h7, 4'h0, 4'h2, 4'h0);
        chk("ppd_pins", 32'({ppd_oe, ppd_pu & 4'ha, 3'h0, wake_req}), 32'h5a1);
        wr(kmp_pkg::ADDR_PPD_OUT, 32'h1);
        keys(3'h7, 3'h7, 4'h0, 4'h0, 4'h0);
        chk("ppd_rel", 32'({ppd_oe, 3'h0, wake_req}), 32'h40);
        wr(kmp_pkg::ADDR_CTRL, 32'h0);
        keys(3'h7, 3'h7, 4'h0, 4'h0, 4'h8);
        chk("grp_in", 32'({grp_oe, grp_pu, 3'h0, wake_req}), 32'h0f1);
        wr(kmp_pkg::ADDR_CTRL, 32'h2);
        wr(kmp_pkg::ADDR_GRP_OUT, 32'h5);
        keys(3'h7, 3'h7, 4'h0, 4'h0, 4'h0);
        chk("grp_out", 32'(grp_oe), 32'ha);
        @(posedge core_clk) wstrb <= 4'he;
        wr(kmp_pkg::ADDR_GRP_OUT, 32'h0);
        wstrb <= 4'hf;
        rdc(kmp_pkg::ADDR_GRP_OUT, 32'h5, "lane0_off");
        @(posedge core_clk) qlvl <= 4'hf;
        keys(3'h7, 3'h7, 4'h4, 4'h0, 4'h0);
        chk("iok_high", 32'(wake_req), 32'h0);
        @(posedge core_clk) qlvl <= 4'h0;
        // wake event into the interrupt status
        wr(kmp_pkg::ADDR_IRQ_MASK, 32'h0);
        keys(3'h7, 3'h7, 4'h4, 4'h0, 4'h0);
        chk("wake_iok", 32'({wake_req, irq}), 32'h2);
        axi_rd(kmp_pkg::ADDR_PINS, d, r);
        chk("pins_iok", 32'(d[7:4]), 32'hb);
        rdc(kmp_pkg::ADDR_IRQ_STAT, 32'h1, "stat_set");
        wr(kmp_pkg::ADDR_IRQ_MASK, 32'h1);
        settle(1);
        chk("irq_on", 32'(irq), 32'h1);
        keys(3'h7, 3'h7, 4'h0, 4'h0, 4'h0);
        wr(kmp_pkg::ADDR_IRQ_STAT, 32'h1);
        settle(2);
        chk("irq_off", 32'(irq), 32'h0);
        rdc(kmp_pkg::ADDR_IRQ_STAT, 32'h0, "stat_clr");
        axi_wr(8'h40, 32'h1, r);
        chk("bresp_bad", 32'(r), 32'(kmp_pkg::RESP_SLVERR));
        axi_rd(8'h40, d, r);
        chk("rd_bad", {d[29:0], r}, 32'(kmp_pkg::RESP_SLVERR));
        final_report();
    end
endmodule
